// >>> shared/clsr_pkg.sv
/*
  Constants, encodings and types for the code lock and signature readout block.
  Assumes a single 10 MHz clock (mclk) which also serves as the oscillator period
  for verify timing.
*/
`default_nettype none

package clsr_pkg;

  // ****************************************************************
  // Array geometry
  // ****************************************************************
  localparam int unsigned ADDR_W      = 14;         // Code address lines
  localparam int unsigned DATA_W      = 8;          // Data lines
  localparam int unsigned ENC_ENTRIES = 64;         // Encryption table bytes
  localparam int unsigned ENC_IDX_W   = 6;          // Address lines picking a table byte
  localparam int unsigned LOCK_BITS   = 3;          // One-time protection bits
  localparam int unsigned CTL_W       = 5;          // Mode control lines

  // Protection bit positions within the lock vector
  localparam int unsigned LB_ONE = 0;
  localparam int unsigned LB_TWO = 1;
  localparam int unsigned LB_THR = 2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS   = 100;    // mclk period
  localparam int unsigned PROG_GAP_MIN_NS = 10000;  // Strobe high between pulses, 10 us
  localparam int unsigned PROG_GAP_CYC    =
    (PROG_GAP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned VERIFY_MAX_OSC  = 48;     // Address to data valid, osc periods

  // ****************************************************************
  // Data values
  // ****************************************************************
  localparam logic [7:0] ERASED_BYTE  = 8'hFF;      // Erased cell contents
  localparam logic [7:0] BLOCKED_BYTE = 8'hFF;      // Shown when verify is locked out
  localparam logic [7:0] NO_SIG_BYTE  = 8'hFF;      // Signature read at other address
  localparam logic [7:0] DENY_BYTE    = 8'h00;      // Fetch data on a refused fetch

  // Signature locations
  localparam logic [13:0] SIG_ADDR_0 = 14'h0030;
  localparam logic [13:0] SIG_ADDR_1 = 14'h0031;
  localparam logic [13:0] SIG_ADDR_2 = 14'h0060;

  // Control line patterns, ordered {p26, p27, p33, p36, p37}
  localparam logic [4:0] PAT_PGM_CODE = 5'h0F;
  localparam logic [4:0] PAT_VERIFY   = 5'h03;
  localparam logic [4:0] PAT_PGM_ENC  = 5'h0D;
  localparam logic [4:0] PAT_PGM_LB1  = 5'h1F;
  localparam logic [4:0] PAT_PGM_LB2  = 5'h1C;
  localparam logic [4:0] PAT_PGM_LB3  = 5'h16;
  localparam logic [4:0] PAT_SIG      = 5'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {LVL_OPEN, LVL_ONE, LVL_TWO, LVL_THREE} clsr_level_t;

  typedef enum logic [2:0] {
    MODE_NONE, MODE_PGM_CODE, MODE_VERIFY, MODE_PGM_ENC,
    MODE_PGM_LB1, MODE_PGM_LB2, MODE_PGM_LB3, MODE_SIG
  } clsr_mode_t;

  typedef enum logic {ER_IDLE, ER_SWEEP} clsr_erase_t;

endpackage

`default_nettype wire

// >>> shared/clsr_mem_if.sv
/*
  Port between the lock controller and its code array store.
  Assumes one access per clock; the store registers its read data.
*/
`default_nettype none

interface clsr_mem_if #(
  parameter int unsigned AW = clsr_pkg::ADDR_W,
  parameter int unsigned DW = clsr_pkg::DATA_W
);
  logic          we;      // Write strobe
  logic [AW-1:0] addr;    // Access address
  logic [DW-1:0] wdata;   // Write data
  logic [DW-1:0] rdata;   // Registered read data

  modport ctrl  (output we, output addr, output wdata, input rdata);
  modport store (input we, input addr, input wdata, output rdata);
endinterface

`default_nettype wire

// >>> src/clsr_code_mem.sv
/*
  Code array store: single port, synchronous write, registered read.
  Assumes contents are nonvolatile; only the read register sees reset.
*/
`default_nettype none

module clsr_code_mem #(
  parameter int unsigned AW = clsr_pkg::ADDR_W,
  parameter int unsigned DW = clsr_pkg::DATA_W
) (
  input  wire logic     mclk,
  input  wire logic     rst_n,
  clsr_mem_if.store     port
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [DW-1:0] cells [2**AW];   // Array cells, not reset
  logic [DW-1:0] rdata_q;         // Read register
  logic [DW-1:0] next_rdata;      // Read value this cycle

  // Cell writes
  always_ff @(posedge mclk) begin
    if (port.we) begin
      cells[port.addr] <= port.wdata;
    end
  end

  // Read path, old data on a same-address write
  always_comb begin
    next_rdata = cells[port.addr];
  end

  // Read register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= next_rdata;
    end
  end

  assign port.rdata = rdata_q;

endmodule

`default_nettype wire

// >>> src/clsr_lock_top.sv
/*
  Code lock and signature readout: protection bits, encryption table,
  programming and verify pin decode, and fetch gating for the CPU.
  Assumes all pins are synchronous to mclk and that the code array is
  wiped by erase_pulse or blank_pulse before first use.
*/
`default_nettype none

// Function
// - Three one-time bits pick protection level
// - Locked part: erase keeps bits, refuses code and table programming
// - Signature bytes at 30H, 31H, 60H
// - No lock: verify still passes through table
// - Level one: block table reads, latch access
// - Level two: also no code verify
// - Level three: also no external execution
// - Other bit patterns undefined; treated as strictest
// - Erase leaves every cell reading all ones
// - Verify data valid within 48 periods
// - Verify output is code XNOR table byte
module clsr_lock_top #(
  parameter logic [7:0] SIG_BYTE_0 = 8'h5A,  // Arbitrary identity value
  parameter logic [7:0] SIG_BYTE_1 = 8'hA5,  // Arbitrary identity value
  parameter logic [7:0] SIG_BYTE_2 = 8'h3C   // Arbitrary identity value
) (
  input  wire logic                         mclk,
  input  wire logic                         rst_n,
  input  wire logic                         prog_select,
  input  wire logic                         psen_n,
  input  wire logic [clsr_pkg::CTL_W-1:0]   ctl_pins,
  input  wire logic                         program_strobe_pin_n,
  input  wire logic                         supply_high,
  input  wire logic                         external_access_pin_n,
  input  wire logic [clsr_pkg::ADDR_W-1:0]  prog_addr,
  input  wire logic [clsr_pkg::DATA_W-1:0]  data_in,
  output logic      [clsr_pkg::DATA_W-1:0]  data_out,
  output logic                              data_oe,
  input  wire logic                         erase_pulse,
  input  wire logic                         blank_pulse,
  output logic                              erase_busy,
  input  wire logic                         fetch_req,
  input  wire logic [clsr_pkg::ADDR_W-1:0]  fetch_addr,
  input  wire logic                         code_table_read_instr,
  input  wire logic                         fetch_from_external,
  output logic                              fetch_ready,
  output logic                              fetch_valid,
  output logic                              fetch_denied,
  output logic      [clsr_pkg::DATA_W-1:0]  fetch_data,
  output logic                              ext_exec_enable,
  output logic                              ext_access_eff_n,
  output logic      [1:0]                   protect_level,
  output logic                              prog_locked
);

  localparam int unsigned GAP_W = $clog2(clsr_pkg::PROG_GAP_CYC + 1);
  localparam int unsigned IW    = clsr_pkg::ENC_IDX_W;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  clsr_mem_if mem ();                              // Store port

  logic [clsr_pkg::LOCK_BITS-1:0] lock_bits;        // 1 = programmed
  logic [clsr_pkg::LOCK_BITS-1:0] next_lock_bits;
  logic [7:0]                     enc_arr [clsr_pkg::ENC_ENTRIES];  // Table cells
  logic                           wipe;             // Erase starts this cycle
  logic                           enc_wr;           // Table write this cycle

  clsr_pkg::clsr_level_t          level, next_level;   // Latched protection level
  logic                           captured, next_captured;
  logic                           ea_latched_n, next_ea_latched_n;

  clsr_pkg::clsr_erase_t          er_state, next_er_state;
  logic [clsr_pkg::ADDR_W-1:0]    sweep_addr, next_sweep_addr;

  logic                           strobe_q, next_strobe_q;   // Last strobe level
  logic [GAP_W-1:0]               gap_cnt, next_gap_cnt;     // Strobe high cycles
  logic                           prog_pulse;                // Accepted pulse
  clsr_pkg::clsr_mode_t           mode;                      // Decoded pin mode
  logic                           any_lock;                  // Live lock state
  logic                           code_wr;                   // Code write this cycle

  logic                           f_pend, next_f_pend;       // Fetch read issued
  logic                           f_deny, next_f_deny;       // Fetch refused
  logic                           v_pend, next_v_pend;       // Verify read issued
  logic [clsr_pkg::ADDR_W-1:0]    v_addr, next_v_addr;       // Verify address
  logic                           next_fetch_valid, next_fetch_denied;
  logic [7:0]                     next_fetch_data, next_data_out;

  // ****************************************************************
  // Pin decode
  // ****************************************************************

  // Mode from control pins, only with programming select and psen low
  always_comb begin
    mode = clsr_pkg::MODE_NONE;
    if (prog_select && !psen_n) begin
      case (ctl_pins)
        clsr_pkg::PAT_PGM_CODE: mode = clsr_pkg::MODE_PGM_CODE;
        clsr_pkg::PAT_VERIFY:   mode = clsr_pkg::MODE_VERIFY;
        clsr_pkg::PAT_PGM_ENC:  mode = clsr_pkg::MODE_PGM_ENC;
        clsr_pkg::PAT_PGM_LB1:  mode = clsr_pkg::MODE_PGM_LB1;
        clsr_pkg::PAT_PGM_LB2:  mode = clsr_pkg::MODE_PGM_LB2;
        clsr_pkg::PAT_PGM_LB3:  mode = clsr_pkg::MODE_PGM_LB3;
        clsr_pkg::PAT_SIG:      mode = clsr_pkg::MODE_SIG;
        default:                mode = clsr_pkg::MODE_NONE;
      endcase
    end
  end

  // ****************************************************************
  // Programming pulse qualification
  // ****************************************************************

  // Falling strobe taken only after a full high gap and with supply up
  always_comb begin
    next_strobe_q = program_strobe_pin_n;
    next_gap_cnt  = gap_cnt;
    if (!program_strobe_pin_n) begin
      next_gap_cnt = '0;
    end else if (gap_cnt < GAP_W'(clsr_pkg::PROG_GAP_CYC)) begin
      next_gap_cnt = gap_cnt + GAP_W'(1);
    end
    prog_pulse = strobe_q && !program_strobe_pin_n && supply_high
                 && (gap_cnt >= GAP_W'(clsr_pkg::PROG_GAP_CYC));
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_q <= 1'b1;
      gap_cnt  <= '0;
    end else begin
      strobe_q <= next_strobe_q;
      gap_cnt  <= next_gap_cnt;
    end
  end

  // ****************************************************************
  // Nonvolatile protection bits and encryption table
  // ****************************************************************

  // Any programmed bit freezes code and table programming
  assign any_lock = |lock_bits;
  assign wipe     = (erase_pulse || blank_pulse) && (er_state == clsr_pkg::ER_IDLE);
  assign enc_wr   = prog_pulse && (mode == clsr_pkg::MODE_PGM_ENC) && !any_lock;
  assign code_wr  = prog_pulse && (mode == clsr_pkg::MODE_PGM_CODE) && !any_lock
                    && (er_state == clsr_pkg::ER_IDLE);

  // Lock bits: set by pulses, cleared only by a blank, kept by erase
  always_comb begin
    next_lock_bits = lock_bits;
    if (blank_pulse && (er_state == clsr_pkg::ER_IDLE)) begin
      next_lock_bits = '0;
    end else if (prog_pulse) begin
      case (mode)
        clsr_pkg::MODE_PGM_LB1: next_lock_bits[clsr_pkg::LB_ONE] = 1'b1;
        clsr_pkg::MODE_PGM_LB2: next_lock_bits[clsr_pkg::LB_TWO] = 1'b1;
        clsr_pkg::MODE_PGM_LB3: next_lock_bits[clsr_pkg::LB_THR] = 1'b1;
        default:                next_lock_bits = lock_bits;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    lock_bits <= next_lock_bits;
  end

  // Table bytes, one cell group per entry
  for (genvar i = 0; i < clsr_pkg::ENC_ENTRIES; i++) begin : g_enc
    logic [7:0] next_enc;  // Next table byte

    always_comb begin
      next_enc = enc_arr[i];
      if (wipe) begin
        next_enc = clsr_pkg::ERASED_BYTE;
      end else if (enc_wr && (prog_addr[IW-1:0] == IW'(i))) begin
        next_enc = data_in;
      end
    end

    always_ff @(posedge mclk) begin
      enc_arr[i] <= next_enc;
    end
  end

  // ****************************************************************
  // Protection level and access pin latch
  // ****************************************************************

  // Level and access pin caught once at the first edge after reset
  always_comb begin
    next_level        = level;
    next_captured     = 1'b1;
    next_ea_latched_n = ea_latched_n;
    if (!captured) begin
      case (lock_bits)
        3'h0:    next_level = clsr_pkg::LVL_OPEN;
        3'h1:    next_level = clsr_pkg::LVL_ONE;
        3'h3:    next_level = clsr_pkg::LVL_TWO;
        3'h7:    next_level = clsr_pkg::LVL_THREE;
        default: next_level = clsr_pkg::LVL_THREE;
      endcase
      next_ea_latched_n = external_access_pin_n;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      level        <= clsr_pkg::LVL_THREE;
      captured     <= 1'b0;
      ea_latched_n <= 1'b0;
    end else begin
      level        <= next_level;
      captured     <= next_captured;
      ea_latched_n <= next_ea_latched_n;
    end
  end

  // Access pin live when open, latched once any level is set
  assign ext_access_eff_n = (level == clsr_pkg::LVL_OPEN) ? external_access_pin_n
                                                          : ea_latched_n;
  assign ext_exec_enable  = (level != clsr_pkg::LVL_THREE);
  assign protect_level    = level;
  assign prog_locked      = any_lock;

  // ****************************************************************
  // Erase sweep
  // ****************************************************************

  // Walk every code address writing erased bytes
  always_comb begin
    next_er_state   = er_state;
    next_sweep_addr = sweep_addr;
    case (er_state)
      clsr_pkg::ER_IDLE: begin
        if (wipe) begin
          next_er_state   = clsr_pkg::ER_SWEEP;
          next_sweep_addr = '0;
        end
      end
      clsr_pkg::ER_SWEEP: begin
        next_sweep_addr = sweep_addr + clsr_pkg::ADDR_W'(1);
        if (&sweep_addr) begin
          next_er_state = clsr_pkg::ER_IDLE;
        end
      end
      default: next_er_state = clsr_pkg::ER_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      er_state   <= clsr_pkg::ER_IDLE;
      sweep_addr <= '0;
    end else begin
      er_state   <= next_er_state;
      sweep_addr <= next_sweep_addr;
    end
  end

  assign erase_busy = (er_state == clsr_pkg::ER_SWEEP);

  // ****************************************************************
  // Store port arbitration
  // ****************************************************************

  // Erase first, then a code write, then pin reads, then CPU fetch
  assign fetch_ready = !prog_select && (er_state == clsr_pkg::ER_IDLE);

  always_comb begin
    mem.we    = 1'b0;
    mem.wdata = data_in;
    mem.addr  = fetch_addr;
    if (er_state == clsr_pkg::ER_SWEEP) begin
      mem.we    = 1'b1;
      mem.addr  = sweep_addr;
      mem.wdata = clsr_pkg::ERASED_BYTE;
    end else if (code_wr) begin
      mem.we   = 1'b1;
      mem.addr = prog_addr;
    end else if (prog_select) begin
      mem.addr = prog_addr;
    end
  end

  clsr_code_mem u_mem (
    .mclk  (mclk),
    .rst_n (rst_n),
    .port  (mem)
  );

  // ****************************************************************
  // Fetch and verify read pipelines
  // ****************************************************************

  // Stage one notes the read; stage two registers the answer
  always_comb begin
    next_f_pend = fetch_req && fetch_ready;
    next_f_deny = fetch_req && fetch_ready && code_table_read_instr
                  && fetch_from_external && (level != clsr_pkg::LVL_OPEN);
    next_v_pend = (mode == clsr_pkg::MODE_VERIFY) && !code_wr
                  && (er_state == clsr_pkg::ER_IDLE);
    next_v_addr = prog_addr;

    next_fetch_valid  = f_pend && !f_deny;
    next_fetch_denied = f_pend && f_deny;
    next_fetch_data   = fetch_data;
    if (f_pend) begin
      next_fetch_data = f_deny ? clsr_pkg::DENY_BYTE : mem.rdata;
    end

    // Signature bytes need no store read
    next_data_out = data_out;
    if (mode == clsr_pkg::MODE_SIG) begin
      case (v_addr)
        clsr_pkg::SIG_ADDR_0: next_data_out = SIG_BYTE_0;
        clsr_pkg::SIG_ADDR_1: next_data_out = SIG_BYTE_1;
        clsr_pkg::SIG_ADDR_2: next_data_out = SIG_BYTE_2;
        default:              next_data_out = clsr_pkg::NO_SIG_BYTE;
      endcase
    end else if (v_pend) begin
      if (level == clsr_pkg::LVL_TWO || level == clsr_pkg::LVL_THREE) begin
        next_data_out = clsr_pkg::BLOCKED_BYTE;
      end else begin
        next_data_out = ~(mem.rdata ^ enc_arr[v_addr[IW-1:0]]);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      f_pend       <= 1'b0;
      f_deny       <= 1'b0;
      v_pend       <= 1'b0;
      v_addr       <= '0;
      fetch_valid  <= 1'b0;
      fetch_denied <= 1'b0;
      fetch_data   <= '0;
      data_out     <= '0;
    end else begin
      f_pend       <= next_f_pend;
      f_deny       <= next_f_deny;
      v_pend       <= next_v_pend;
      v_addr       <= next_v_addr;
      fetch_valid  <= next_fetch_valid;
      fetch_denied <= next_fetch_denied;
      fetch_data   <= next_fetch_data;
      data_out     <= next_data_out;
    end
  end

  // Data lines driven in verify or signature mode with strobe high and supply_high low
  assign data_oe = ((mode == clsr_pkg::MODE_VERIFY) || (mode == clsr_pkg::MODE_SIG))
                   && program_strobe_pin_n && !supply_high;

endmodule

`default_nettype wire

// >>> bench/clsr_lock_checker.sv
/* Port assertions for the lock block.
   Assumes one clock, async active-low reset. */
`default_nettype none
module clsr_lock_checker (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       prog_select,
  input wire logic       program_strobe_pin_n,
  input wire logic       supply_high,
  input wire logic       external_access_pin_n,
  input wire logic       fetch_req,
  input wire logic       code_table_read_instr,
  input wire logic       fetch_from_external,
  input wire logic       fetch_ready,
  input wire logic       fetch_valid,
  input wire logic       fetch_denied,
  input wire logic [7:0] fetch_data,
  input wire logic       ext_exec_enable,
  input wire logic       ext_access_eff_n,
  input wire logic [1:0] protect_level,
  input wire logic       data_oe,
  input wire logic       erase_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic tk;  // Fetch taken
  assign tk = fetch_req && fetch_ready;
  fetch_answer_a: assert property (tk |-> ##2 (fetch_valid ^ fetch_denied))
    else $error("fetch not answered");
  deny_rule_a: assert property (tk && code_table_read_instr && fetch_from_external
    |-> ##2 (fetch_denied == (protect_level != 2'h0))) else $error("fetch deny wrong");
  deny_data_a: assert property (fetch_denied |-> fetch_data == 8'h00)
    else $error("denied data not zero");
  ext_exec_a: assert property (ext_exec_enable == (protect_level != 2'h3))
    else $error("external execution gate wrong");
  level_hold_a: assert property ($past(rst_n, 2) |-> $stable(protect_level))
    else $error("level moved");
  access_open_a: assert property (protect_level == 2'h0
    |-> ext_access_eff_n == external_access_pin_n) else $error("access pin not live");
  access_latch_a: assert property ($past(rst_n, 2) && protect_level != 2'h0
    |-> $stable(ext_access_eff_n)) else $error("access pin not latched");
  fetch_block_a: assert property (fetch_ready == !(prog_select || erase_busy))
    else $error("fetch ready wrong");
  drive_gate_a: assert property (data_oe |-> program_strobe_pin_n && !supply_high)
    else $error("data driven while programming");
  cover property (fetch_denied);
  cover property (protect_level == 2'h3);
  cover property (data_oe && prog_select);
endmodule
bind clsr_lock_top clsr_lock_checker chk (.mclk, .rst_n, .prog_select,
  .program_strobe_pin_n, .supply_high, .external_access_pin_n, .fetch_req,
  .code_table_read_instr, .fetch_from_external, .fetch_ready, .fetch_valid,
  .fetch_denied, .fetch_data, .ext_exec_enable, .ext_access_eff_n, .protect_level,
  .data_oe, .erase_busy);
`default_nettype wire

// >>> bench/clsr_prog_model.sv
/* Programmer model: pulse trains and verify reads.
   Assumes tasks are called at a falling edge. */
`default_nettype none
module clsr_prog_model (
  input  wire logic       mclk,
  output logic            prog_select,
  output logic            psen_n,
  output logic [4:0]      ctl_pins,
  output logic            program_strobe_pin_n,
  output logic            supply_high,
  output logic [13:0]     prog_addr,
  output logic [7:0]      data_in,
  input  wire logic [7:0] data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {prog_select, supply_high, prog_addr, data_in} = '0;
    {psen_n, program_strobe_pin_n, ctl_pins} = '1;
  end
  // Strobe high 101 cycles before each low cycle
  task automatic burn(input logic [4:0] p, input logic [13:0] a, input logic [7:0] d,
                      input int n);
    {prog_select, psen_n, ctl_pins, prog_addr, data_in} = {2'b10, p, a, d};
    supply_high = 1'b1;
    repeat (n) begin
      repeat (101) @(negedge mclk);
      program_strobe_pin_n = 1'b0;
      @(negedge mclk);
      program_strobe_pin_n = 1'b1;
    end
    @(negedge mclk);
    {prog_select, psen_n, supply_high, data_in} = {2'b01, 1'b0, ~d};
  endtask
  // Verify or signature read, pattern chosen by caller
  task automatic peek(input logic [4:0] p, input logic [13:0] a, output logic [7:0] q);
    {prog_select, psen_n, ctl_pins, prog_addr} = {2'b10, p, a};
    repeat (4) @(negedge mclk);
    q = data_out;
    {prog_select, psen_n} = 2'b01;
  endtask
endmodule
`default_nettype wire

// >>> bench/clsr_lock_bench.sv
/* Self-checking bench for the lock block.
   Assumes the checker is bound by its own file. */
`default_nettype none
module clsr_lock_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst_n, prog_select, psen_n, program_strobe_pin_n, supply_high;
  logic external_access_pin_n, erase_pulse, blank_pulse, fetch_req;
  logic code_table_read_instr, fetch_from_external, data_oe, erase_busy, fetch_ready;
  logic fetch_valid, fetch_denied, ext_exec_enable, ext_access_eff_n, prog_locked;
  logic [4:0]  ctl_pins;
  logic [13:0] prog_addr, fetch_addr;
  logic [7:0]  data_in, data_out, fetch_data;
  logic [1:0]  protect_level;
  logic [13:0] sa [4] = '{14'h0030, 14'h0031, 14'h0060, 14'h0032};
  logic [7:0]  sv [4] = '{8'h12, 8'h34, 8'h56, 8'hFF};
  int fail_count = 0, n_compared = 0, cyc = 0;
  clsr_lock_top #(.SIG_BYTE_0(8'h12), .SIG_BYTE_1(8'h34), .SIG_BYTE_2(8'h56)) uut (
    .mclk, .rst_n, .prog_select, .psen_n, .ctl_pins, .program_strobe_pin_n,
    .supply_high, .external_access_pin_n, .prog_addr, .data_in, .data_out, .data_oe,
    .erase_pulse, .blank_pulse, .erase_busy, .fetch_req, .fetch_addr,
    .code_table_read_instr, .fetch_from_external, .fetch_ready, .fetch_valid,
    .fetch_denied, .fetch_data, .ext_exec_enable, .ext_access_eff_n, .protect_level,
    .prog_locked);
  clsr_prog_model pm (.mclk, .prog_select, .psen_n, .ctl_pins, .program_strobe_pin_n,
    .supply_high, .prog_addr, .data_in, .data_out);
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      report_and_stop;
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d, mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic do_reset;
    rst_n = 1'b0;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
  endtask
  task automatic wipe(input logic b);
    {blank_pulse, erase_pulse} = {b, !b};
    @(negedge mclk);
    {blank_pulse, erase_pulse} = 2'b00;
    for (int i = 0; i < 17000 && erase_busy; i++) @(negedge mclk);
    chk("erase_busy", 8'h00, {7'h0, erase_busy});
  endtask
  task automatic vchk(input logic [4:0] p, input logic [13:0] a, input logic [7:0] e);
    logic [7:0] q;
    pm.peek(p, a, q);
    chk("data_out", e, q);
  endtask
  // One fetch; r is the expected {valid, denied}
  task automatic fetch(input logic t, input logic [1:0] r, input logic [7:0] d);
    {fetch_req, fetch_addr} = {1'b1, 14'h0105};
    {code_table_read_instr, fetch_from_external} = {t, 1'b1};
    @(negedge mclk);
    fetch_req = 1'b0;
    @(negedge mclk);
    chk("fetch_answer", {6'h0, r}, {6'h0, fetch_valid, fetch_denied});
    chk("fetch_data", d, fetch_data);
  endtask
  task automatic lvl(input logic [1:0] e, input logic x);
    chk("protect_level", {6'h0, e}, {6'h0, protect_level});
    chk("ext_exec_enable", {7'h0, x}, {7'h0, ext_exec_enable});
    chk("prog_locked", {7'h0, e != 2'h0}, {7'h0, prog_locked});
  endtask
  initial begin
    {rst_n, erase_pulse, blank_pulse, fetch_req, fetch_addr} = '0;
    {code_table_read_instr, fetch_from_external, external_access_pin_n} = 3'b001;
    do_reset;
    wipe(1'b1);
    do_reset;
    lvl(2'h0, 1'b1);
    vchk(clsr_pkg::PAT_VERIFY, 14'h0105, 8'hFF);
    pm.burn(clsr_pkg::PAT_PGM_ENC, 14'h0005, 8'h0F, 25);
    pm.burn(clsr_pkg::PAT_PGM_CODE, 14'h0105, 8'h3C, 5);
    vchk(clsr_pkg::PAT_VERIFY, 14'h0105, 8'hCC);
    for (int i = 0; i < 4; i++) vchk(clsr_pkg::PAT_SIG, sa[i], sv[i]);
    fetch(1'b1, 2'b10, 8'h3C);
    pm.burn(clsr_pkg::PAT_PGM_LB1, 14'h0000, 8'hFF, 25);
    external_access_pin_n = 1'b0;
    do_reset;
    external_access_pin_n = 1'b1;
    @(negedge mclk);
    lvl(2'h1, 1'b1);
    chk("ext_access_eff_n", 8'h00, {7'h0, ext_access_eff_n});
    fetch(1'b1, 2'b01, 8'h00);
    fetch(1'b0, 2'b10, 8'h3C);
    pm.burn(clsr_pkg::PAT_PGM_CODE, 14'h0105, 8'h00, 5);
    vchk(clsr_pkg::PAT_VERIFY, 14'h0105, 8'hCC);
    pm.burn(clsr_pkg::PAT_PGM_LB2, 14'h0000, 8'hFF, 25);
    lvl(2'h1, 1'b1);
    do_reset;
    lvl(2'h2, 1'b1);
    vchk(clsr_pkg::PAT_VERIFY, 14'h0105, 8'hFF);
    wipe(1'b0);
    do_reset;
    lvl(2'h2, 1'b1);
    pm.burn(clsr_pkg::PAT_PGM_LB3, 14'h0000, 8'hFF, 25);
    do_reset;
    lvl(2'h3, 1'b0);
    report_and_stop;
  end
endmodule
`default_nettype wire
